// file: rtl/asf_regs.svh
// offsets, field positions, reset values and limits of the angle status bank
`ifndef ASF_REGS_SVH
`define ASF_REGS_SVH
`define ASF_CTRL_ADDR 8'h1E
`define ASF_ANGLE_ADDR 8'h20
`define ASF_STATUS_ADDR 8'h22
`define ASF_ERR_ADDR 8'h24
`define ASF_WARN_ADDR 8'h26
`define ASF_TEMP_ADDR 8'h28
`define ASF_FIELD_ADDR 8'h2A
`define ASF_HYS_ADDR 8'h30
`define ASF_CTL_ERR_CLR 8
`define ASF_CTL_WARN_CLR 9
`define ASF_CTL_STAT_CLR 10
`define ASF_ERR_RESET 11'h001
`define ASF_MASK_CAUTION 11
`define ASF_MASK_LOW_ANALOG 2
`define ASF_MASK_LOW_DIGITAL 3
`define ASF_TEMP_LO_C (-60)
`define ASF_TEMP_HI_C 180
`define ASF_TEMP_REF_C 25
`define ASF_TEMP_STEPS 8
`endif

// file: rtl/asf_pkg.sv
// types shared by the angle status bank
`default_nettype none
package asf_pkg;
  typedef struct packed {
    logic hard_reset;
    logic osc_wdog;
    logic ecc_multi;
    logic zc_timeout;
    logic quad_fault;
    logic avg_fault;
    logic selftest_fail;
  } asf_err_evt_t;
  typedef struct packed {
    logic saturated;
    logic ecc_single;
    logic ext_overlap;
    logic ext_write_fail;
    logic slew_limit;
    logic crc_bad;
    logic frame_bad;
  } asf_warn_evt_t;
endpackage
`default_nettype wire

// file: rtl/asf_status_bank.sv
// read-only angle, status, error and caution register bank
`timescale 1ns/1ps
`default_nettype none
`include "asf_regs.svh"
module asf_status_bank import asf_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [11:0] angle,
  input wire logic [11:0] hys_angle,
  input wire logic pll_lock,
  input wire logic boot_busy,
  input wire logic xdcr_test_run,
  input wire logic logic_test_run,
  input wire logic boot_done,
  input wire logic special_start,
  input wire logic special_done,
  input wire logic rot_decreasing,
  input wire logic [1:0] die_index,
  input wire logic low_analog_pin,
  input wire logic low_digital_pin,
  input wire logic [11:0] field_gauss,
  input wire logic [11:0] field_low_limit,
  input wire logic [11:0] field_strong_limit,
  input wire logic signed [15:0] temp_raw,
  input wire logic [23:0] mask_word,
  input wire asf_err_evt_t err_evt,
  input wire asf_warn_evt_t warn_evt
);

  localparam logic signed [15:0] TEMP_LO = 16'(
    (`ASF_TEMP_LO_C - `ASF_TEMP_REF_C) * `ASF_TEMP_STEPS);
  localparam logic signed [15:0] TEMP_HI = 16'(
    (`ASF_TEMP_HI_C - `ASF_TEMP_REF_C) * `ASF_TEMP_STEPS);

  // angle words share layout: zero, fault, supply-low, parity, angle
  function automatic logic [15:0] angle_word(input logic [11:0] a,
                                             input logic flt,
                                             input logic low);
    angle_word = {1'b0, flt, low, ~^{flt, low, a}, a};
  endfunction

  // clear only what software already saw; a new event always wins
  function automatic logic [11:0] latch_next(input logic [11:0] cur,
                                             input logic [11:0] seen,
                                             input logic [11:0] set,
                                             input logic clr);
    latch_next = (clr ? (cur & ~seen) : cur) | set;
  endfunction

  // caution bits sit at scattered positions of the mask word
  function automatic logic [11:0] warn_mask(input logic [23:0] m);
    warn_mask = {m[23], m[22], 1'b0, m[20], m[19], m[18],
                 m[17], m[16], 1'b0, m[14], m[13], 1'b0};
  endfunction

  // supply detectors are analog and asynchronous to clk_sys
  logic [1:0] low_s1;
  logic [1:0] low_s2;
  logic pll_lock_q;
  logic [10:0] err_lat;
  logic [11:0] warn_lat;
  logic [11:0] seen_err;
  logic [11:0] seen_warn;
  logic boot_cmp;
  logic special_cmp;
  logic [7:0] rd_addr_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      low_s1 <= 2'h0;
      low_s2 <= 2'h0;
      pll_lock_q <= 1'b0;
    end else begin
      low_s1 <= {low_digital_pin, low_analog_pin};
      low_s2 <= low_s1;
      pll_lock_q <= pll_lock;
    end
  end

  wire ctl_wr = reg_wr && (reg_addr == `ASF_CTRL_ADDR);
  wire err_clr = ctl_wr && reg_wdata[`ASF_CTL_ERR_CLR];
  wire warn_clr = ctl_wr && reg_wdata[`ASF_CTL_WARN_CLR];
  wire status_clr = ctl_wr && reg_wdata[`ASF_CTL_STAT_CLR];
  wire rd_err = reg_rd && (reg_addr == `ASF_ERR_ADDR);
  wire rd_warn = reg_rd && (reg_addr == `ASF_WARN_ADDR);

  wire lock_lost = pll_lock_q && !pll_lock;
  wire field_low = field_gauss < field_low_limit;
  wire field_high = field_gauss > field_strong_limit;
  wire temp_below = temp_raw < TEMP_LO;
  wire temp_above = temp_raw > TEMP_HI;

  wire [11:0] err_set = {1'b0,
    err_evt.selftest_fail, err_evt.avg_fault,
    err_evt.quad_fault,
    lock_lost, err_evt.zc_timeout, err_evt.ecc_multi,
    err_evt.osc_wdog,
    low_s2[1], low_s2[0], field_low,
    err_evt.hard_reset};

  wire [11:0] warn_set = {warn_evt.frame_bad,
    warn_evt.crc_bad, 1'b0, warn_evt.slew_limit,
    warn_evt.ext_write_fail,
    temp_below || temp_above,
    warn_evt.ecc_single, warn_evt.saturated, 1'b0,
    warn_evt.ext_overlap, field_high, 1'b0};

  wire [11:0] next_err = latch_next({1'b0, err_lat}, seen_err,
                                    err_set, err_clr);
  wire [11:0] next_warn = latch_next(warn_lat, seen_warn,
                                     warn_set, warn_clr);

  // the reset flag comes up set: the async reset is the power-on event
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      err_lat <= `ASF_ERR_RESET;
      warn_lat <= 12'h000;
    end else begin
      err_lat <= next_err[10:0];
      warn_lat <= next_warn;
    end
  end

  // a read snapshots what software saw; a clear consumes it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      seen_err <= 12'h000;
      seen_warn <= 12'h000;
    end else begin
      if (rd_err)
        seen_err <= {1'b0, err_lat};
      else if (err_clr)
        seen_err <= 12'h000;
      if (rd_warn)
        seen_warn <= warn_lat;
      else if (warn_clr)
        seen_warn <= 12'h000;
    end
  end

  // completion events win over the status clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      boot_cmp <= 1'b0;
      special_cmp <= 1'b0;
    end else begin
      if (boot_done)
        boot_cmp <= 1'b1;
      else if (status_clr)
        boot_cmp <= 1'b0;
      if (special_done)
        special_cmp <= 1'b1;
      else if (special_start || status_clr)
        special_cmp <= 1'b0;
    end
  end

  wire [11:0] wmask = warn_mask(mask_word);
  wire caution_sum = |(warn_lat & ~wmask) &&
    !mask_word[`ASF_MASK_CAUTION];
  wire [11:0] err_word12 = {caution_sum, err_lat};
  wire any_fault = |(err_word12 & ~mask_word[11:0]) ||
    |(warn_lat & ~wmask);
  wire supply_low_live = (low_s2[0] && !mask_word[`ASF_MASK_LOW_ANALOG]) ||
    (low_s2[1] && !mask_word[`ASF_MASK_LOW_DIGITAL]);

  wire [15:0] angle_rd_word = angle_word(angle, any_fault,
    supply_low_live);
  wire [15:0] hys_rd_word = angle_word(hys_angle, any_fault,
    supply_low_live);
  wire [15:0] status_word = {6'h00, die_index,
    rot_decreasing, 1'b0, special_cmp, boot_cmp,
    logic_test_run, xdcr_test_run, boot_busy, pll_lock};
  wire [15:0] err_word = {4'h0, err_word12};
  wire [15:0] warn_word = {4'h0, warn_lat};
  wire signed [15:0] temp_sat = temp_below ? TEMP_LO :
    temp_above ? TEMP_HI : temp_raw;
  wire [15:0] temp_word = {4'h0, temp_sat[11:0]};
  wire [15:0] field_word = {4'h0, field_gauss};

  // control word and unmapped offsets read zero
  wire [15:0] rd_mux =
    (reg_addr == `ASF_ANGLE_ADDR) ? angle_rd_word :
    (reg_addr == `ASF_STATUS_ADDR) ? status_word :
    (reg_addr == `ASF_ERR_ADDR) ? err_word :
    (reg_addr == `ASF_WARN_ADDR) ? warn_word :
    (reg_addr == `ASF_TEMP_ADDR) ? temp_word :
    (reg_addr == `ASF_FIELD_ADDR) ? field_word :
    (reg_addr == `ASF_HYS_ADDR) ? hys_rd_word :
    16'h0000;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
      rd_addr_q <= 8'h00;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_mux;
        rd_addr_q <= reg_addr;
      end
    end
  end

  default clocking dflt_cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  angle_parity_a: assert property (
    reg_rvalid && (rd_addr_q == `ASF_ANGLE_ADDR ||
      rd_addr_q == `ASF_HYS_ADDR) |-> (^reg_rdata) == 1'b1)
    else $error("angle word parity not odd");

  angle_value_a: assert property (
    reg_rd && reg_addr == `ASF_ANGLE_ADDR
      |=> reg_rdata[11:0] == $past(angle))
    else $error("angle field not returned");

  supply_live_a: assert property (
    low_analog_pin [*3] ##0 !mask_word[`ASF_MASK_LOW_ANALOG] |->
      angle_rd_word[13])
    else $error("live supply-low bit missing");

  fault_sum_a: assert property (
    (err_word12 & ~mask_word[11:0]) != 12'h000 |-> any_fault &&
      hys_rd_word[14])
    else $error("fault summary not set");

  err_hold_a: assert property (
    !err_clr |=> (err_lat & $past(err_lat)) == $past(err_lat))
    else $error("error bit dropped without clear");

  err_clear_a: assert property (
    err_clr |=> ({1'b0, err_lat} & ~$past(seen_err)) ==
      (({1'b0, $past(err_lat)} | $past(err_set)) & ~$past(seen_err)))
    else $error("error clear touched unread bits");

  warn_clear_a: assert property (
    warn_clr && warn_set == 12'h000 |=>
      (warn_lat & $past(seen_warn)) == 12'h000)
    else $error("read caution bits not cleared");

  reset_flag_a: assert property (
    err_evt.hard_reset |=> err_lat[0] ##1 err_lat[0] || $past(err_clr))
    else $error("reset flag not latched");

  lock_lost_a: assert property (
    $fell(pll_lock) |=> err_lat[7])
    else $error("lock loss not latched");

  special_clr_a: assert property (
    special_start && !special_done |=> !special_cmp)
    else $error("special complete not cleared on start");

  special_set_a: assert property (
    special_done |=> special_cmp)
    else $error("special complete not set when done");

  stat_clear_a: assert property (
    status_clr && !special_done && !boot_done |=> !special_cmp
      && !boot_cmp)
    else $error("status clear did not drop done bits");

  ctrl_read_a: assert property (
    reg_rd && reg_addr == `ASF_CTRL_ADDR |=> reg_rdata == 16'h0000)
    else $error("control word did not read zero");

  temp_sat_a: assert property (
    temp_raw > TEMP_HI |-> temp_word[11:0] == TEMP_HI[11:0]
      && warn_set[6])
    else $error("temperature not saturated high");

  caution_mask_a: assert property (
    mask_word[`ASF_MASK_CAUTION] |-> !err_word[11])
    else $error("masked caution summary set");

  status_live_a: assert property (
    reg_rd && reg_addr == `ASF_STATUS_ADDR |=> reg_rdata[3:0] ==
      $past({logic_test_run, xdcr_test_run, boot_busy, pll_lock}))
    else $error("status live bits wrong");

  status_dir_a: assert property (
    reg_rd && reg_addr == `ASF_STATUS_ADDR |=> reg_rdata[7] ==
      $past(rot_decreasing))
    else $error("rotation direction bit wrong");

  die_index_a: assert property (
    reg_rd && reg_addr == `ASF_STATUS_ADDR |=> reg_rdata[9:8] ==
      $past(die_index))
    else $error("die index field wrong");

  status_zero_a: assert property (
    reg_rvalid && rd_addr_q == `ASF_STATUS_ADDR |->
      reg_rdata[15:10] == 6'h00 && !reg_rdata[6])
    else $error("undefined status bits set");

  boot_done_a: assert property (
    boot_done |=> boot_cmp)
    else $error("boot complete not set");

  field_low_a: assert property (
    field_gauss < field_low_limit |=> err_lat[1])
    else $error("field-low error not latched");

  supply_err_a: assert property (
    low_s2 != 2'h0 |=> (err_lat[3:2] & $past(low_s2)) == $past(low_s2))
    else $error("supply-low error not latched");

  supply_dig_a: assert property (
    low_digital_pin [*3] ##0 !mask_word[`ASF_MASK_LOW_DIGITAL] |->
      angle_rd_word[13])
    else $error("live digital supply-low bit missing");

  quad_fault_a: assert property (
    err_evt.quad_fault |=> err_lat[8])
    else $error("quadrature fault not latched");

  strong_field_a: assert property (
    field_gauss > field_strong_limit |=> warn_lat[1])
    else $error("strong field caution not latched");

  frame_bad_a: assert property (
    warn_evt.frame_bad |=> warn_lat[11])
    else $error("frame caution not latched");

  warn_hold_a: assert property (
    !warn_clr |=> (warn_lat & $past(warn_lat)) == $past(warn_lat))
    else $error("caution bit dropped without clear");

  temp_low_a: assert property (
    temp_raw < TEMP_LO |-> temp_word[11:0] == TEMP_LO[11:0]
      && warn_set[6])
    else $error("temperature not saturated low");

  field_word_a: assert property (
    reg_rd && reg_addr == `ASF_FIELD_ADDR |=>
      reg_rdata == {4'h0, $past(field_gauss)})
    else $error("field strength word wrong");

  clear_after_read_c: cover property (
    rd_err && err_lat != 11'h000 ##[1:8] err_clr);
  special_cycle_c: cover property (
    special_start ##[1:20] special_done);
  temp_range_c: cover property (temp_above ##[1:50] temp_below);
  masked_supply_c: cover property (
    low_s2[0] && mask_word[`ASF_MASK_LOW_ANALOG]);
  caution_masked_c: cover property (
    warn_lat != 12'h000 && mask_word[`ASF_MASK_CAUTION]);

endmodule // asf_status_bank
`default_nettype wire

// file: test/asf_status_bank_tb.sv
// self-checking bench for the angle status register bank
`timescale 1ns/1ps
`default_nettype none
module asf_status_bank_tb import asf_pkg::*; ;
  logic clk_sys = 1'b0, rst_n = 1'b0, reg_rd = 1'b0, reg_wr = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic reg_rvalid;
  logic [11:0] angle = 12'h000, hys_angle = 12'h000;
  logic pll_lock = 1'b1, boot_busy = 1'b0, xdcr_test_run = 1'b0;
  logic logic_test_run = 1'b0, boot_done = 1'b0, special_start = 1'b0;
  logic special_done = 1'b0, rot_decreasing = 1'b0;
  logic low_analog_pin = 1'b0, low_digital_pin = 1'b0;
  logic [1:0] die_index = 2'h0;
  logic [11:0] field_gauss = 12'h064, field_low_limit = 12'h00A;
  logic [11:0] field_strong_limit = 12'hFA0;
  logic signed [15:0] temp_raw = 16'sh0000;
  logic [23:0] mask_word = 24'h000000;
  asf_err_evt_t err_evt = '0;
  asf_warn_evt_t warn_evt = '0;
  int n_errors = 0, n_compared = 0;
  asf_status_bank dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .angle(angle),
    .hys_angle(hys_angle), .pll_lock(pll_lock), .boot_busy(boot_busy),
    .xdcr_test_run(xdcr_test_run), .logic_test_run(logic_test_run),
    .boot_done(boot_done), .special_start(special_start),
    .special_done(special_done), .rot_decreasing(rot_decreasing),
    .die_index(die_index), .low_analog_pin(low_analog_pin),
    .low_digital_pin(low_digital_pin), .field_gauss(field_gauss),
    .field_low_limit(field_low_limit),
    .field_strong_limit(field_strong_limit), .temp_raw(temp_raw),
    .mask_word(mask_word), .err_evt(err_evt), .warn_evt(warn_evt));
  always #4 clk_sys = ~clk_sys;
  task automatic give_verdict;
    if (n_errors == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // answer counts only when the valid pulse stands beside it
  task automatic rc(input logic [7:0] a, input logic [15:0] exp);
    @(negedge clk_sys);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    chk($sformatf("word %h", a), reg_rvalid ? reg_rdata : 16'hXXXX, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask
  task automatic t_reset;
    rc(8'h24, 16'h0001);
    rc(8'h26, 16'h0000);
    rc(8'h22, 16'h0001);
    wr(8'h1E, 16'h0100);
    rc(8'h24, 16'h0000);
  endtask
  task automatic t_angle;
    logic [11:0] tv [4] = '{12'h000, 12'hFFF, 12'h555, 12'h801};
    foreach (tv[i]) begin
      angle = tv[i];
      hys_angle = ~tv[i];
      rc(8'h20, {3'b000, ~^tv[i], tv[i]});
      rc(8'h30, {3'b000, ~^tv[i], ~tv[i]});
    end
    angle = 12'h000;
    hys_angle = 12'h000;
  endtask
  task automatic t_status;
    {boot_busy, xdcr_test_run, logic_test_run, rot_decreasing} = 4'hF;
    die_index = 2'h2;
    boot_done = 1'b1;
    special_done = 1'b1;
    wait_n(1);
    {boot_done, special_done} = 2'b00;
    rc(8'h22, 16'h02BF);
    special_start = 1'b1;
    wait_n(1);
    special_start = 1'b0;
    rc(8'h22, 16'h029F);
    special_done = 1'b1;
    wait_n(1);
    special_done = 1'b0;
    rc(8'h22, 16'h02BF);
    wr(8'h1E, 16'h0400);
    rc(8'h22, 16'h028F);
    rc(8'h1E, 16'h0000);
    rc(8'h2C, 16'h0000);
    {boot_busy, xdcr_test_run, logic_test_run, rot_decreasing} = 4'h0;
    die_index = 2'h0;
  endtask
  task automatic t_errors;
    int pos [7] = '{0, 4, 5, 6, 8, 9, 10};
    foreach (pos[i]) begin
      err_evt = asf_err_evt_t'(7'h40 >> i);
      wait_n(1);
      err_evt = '0;
      rc(8'h24, 16'h0001 << pos[i]);
      wr(8'h1E, 16'h0100);
      rc(8'h24, 16'h0000);
    end
    err_evt.osc_wdog = 1'b1;
    wait_n(1);
    err_evt = '0;
    rc(8'h24, 16'h0010);
    err_evt.quad_fault = 1'b1;
    wait_n(1);
    err_evt = '0;
    wr(8'h1E, 16'h0100);
    wr(8'h24, 16'h0100);
    rc(8'h24, 16'h0100);
    wr(8'h1E, 16'h0100);
    field_gauss = 12'h005;
    pll_lock = 1'b0;
    wait_n(3);
    field_gauss = 12'h064;
    pll_lock = 1'b1;
    rc(8'h24, 16'h0082);
    wr(8'h1E, 16'h0100);
    rc(8'h24, 16'h0000);
  endtask
  task automatic t_supply;
    low_analog_pin = 1'b1;
    wait_n(4);
    rc(8'h20, 16'h7000);
    rc(8'h30, 16'h7000);
    rc(8'h24, 16'h0004);
    wr(8'h1E, 16'h0100);
    wait_n(2);
    rc(8'h24, 16'h0004);
    mask_word = 24'h000004;
    rc(8'h20, 16'h1000);
    {low_analog_pin, low_digital_pin} = 2'b01;
    wait_n(4);
    rc(8'h20, 16'h7000);
    low_digital_pin = 1'b0;
    mask_word = 24'h000000;
    wait_n(4);
    rc(8'h24, 16'h000C);
    wr(8'h1E, 16'h0100);
  endtask
  task automatic t_warn;
    int pos [7] = '{4, 5, 2, 7, 8, 10, 11};
    foreach (pos[i]) begin
      warn_evt = asf_warn_evt_t'(7'h40 >> i);
      wait_n(1);
      warn_evt = '0;
      rc(8'h26, 16'h0001 << pos[i]);
      rc(8'h24, 16'h0800);
      wr(8'h1E, 16'h0200);
      rc(8'h26, 16'h0000);
    end
    field_gauss = 12'hFA1;
    wait_n(2);
    field_gauss = 12'h064;
    rc(8'h26, 16'h0002);
    mask_word = 24'h000800;
    rc(8'h24, 16'h0000);
    mask_word = 24'h000000;
    wr(8'h1E, 16'h0200);
  endtask
  task automatic t_temp;
    temp_raw = 16'sd256;
    wait_n(2);
    rc(8'h28, 16'h0100);
    rc(8'h2A, 16'h0064);
    temp_raw = 16'sd2000;
    wait_n(2);
    rc(8'h28, 16'h04D8);
    rc(8'h26, 16'h0040);
    temp_raw = -16'sd1000;
    wait_n(2);
    rc(8'h28, 16'h0D58);
  endtask
  initial begin
    wait_n(12);
    rst_n = 1'b1;
    t_reset();
    t_angle();
    t_status();
    t_errors();
    t_supply();
    t_warn();
    t_temp();
    give_verdict();
  end
  // the whole sequence needs well under 2000 cycles
  initial begin
    #100000;
    n_errors++;
    give_verdict();
  end
endmodule // asf_status_bank_tb
`default_nettype wire
